/* File: bsrs_defines.svh */
// Named constants for the bonded transceiver reset and lock model
`ifndef BSRS_DEFINES_SVH
`define BSRS_DEFINES_SVH

// Clock and counter sizing
`define BSRS_CLK_PERIOD_NS 20
`define BSRS_CNT_W 12
`define BSRS_N_LANES 4

// Device timing figures in ns and derived cycle counts
`define BSRS_PLL_LOCK_NS 2000
`define BSRS_PLL_LOCK_CYC ((`BSRS_PLL_LOCK_NS) / (`BSRS_CLK_PERIOD_NS))
`define BSRS_OFFSET_CANCEL_NS 4000
`define BSRS_OFFSET_CANCEL_CYC ((`BSRS_OFFSET_CANCEL_NS) / (`BSRS_CLK_PERIOD_NS))
`define BSRS_RECONF_BUSY_NS 200
`define BSRS_RECONF_BUSY_CYC ((`BSRS_RECONF_BUSY_NS) / (`BSRS_CLK_PERIOD_NS))
`define BSRS_AUTO_LTD_NS 1000
`define BSRS_AUTO_LTD_CYC ((`BSRS_AUTO_LTD_NS) / (`BSRS_CLK_PERIOD_NS))
`define BSRS_LANE_SKEW_CYC 8

// Register byte addresses
`define BSRS_REG_CONFIG 8'h00
`define BSRS_REG_STATUS 8'h04
`define BSRS_REG_LOCK 8'h08
`define BSRS_REG_RECONF 8'h0C

// Field positions and reset values
`define BSRS_CFG_MODE_LSB 0
`define BSRS_CFG_MODE_MSB 1
`define BSRS_CFG_TXONLY_BIT 2
`define BSRS_CFG_MODE_RESET 2'h3
`define BSRS_LOCK_MODE_LSB 4
`define BSRS_ALL_LANES 4'hF

`endif

/* File: bsrs_pkg.sv */
// Types shared by the bonded transceiver reset and lock model
`include "bsrs_defines.svh"
package bsrs_pkg;

   // Reconfiguration busy sequencing, Gray along the power-up path
   typedef enum logic [1:0] {
      OC_FIRST = 2'h0,
      OC_CANCEL = 2'h1,
      OC_IDLE = 2'h3,
      OC_RECONF = 2'h2
   } bsrs_oc_state_type;

   // Clock-data-recovery state per lane
   typedef enum logic [1:0] {
      CDR_HOLD = 2'h0,
      CDR_REF = 2'h1,
      CDR_DATA = 2'h3
   } bsrs_cdr_state_type;

   // Lock controller mode seen by a lane
   typedef enum logic [1:0] {
      LOCK_AUTO = 2'h0,
      LOCK_MAN_REF = 2'h1,
      LOCK_MAN_DATA = 2'h2
   } bsrs_lock_mode_type;

   // Bonding arrangement
   typedef enum logic [1:0] {
      BOND_X1 = 2'h0,
      BOND_X2 = 2'h1,
      BOND_X4 = 2'h2,
      BOND_XAUI = 2'h3
   } bsrs_bond_type;

   // Reset and lock controls from the fabric reset controller
   typedef struct packed {
      logic pll_reset;
      logic tx_digital_reset;
      logic rx_analog_reset;
      logic rx_digital_reset;
      logic [`BSRS_N_LANES-1:0] lock_to_reference;
      logic [`BSRS_N_LANES-1:0] lock_to_data;
   } bsrs_ctrl_type;

   // Status returned to the fabric reset controller
   typedef struct packed {
      logic pll_locked;
      logic reconfig_busy;
      logic [`BSRS_N_LANES-1:0] rx_freq_locked;
      logic tx_ready;
      logic rx_ready;
   } bsrs_stat_type;

endpackage : bsrs_pkg

/* File: bsrs_reconf_busy.sv */
// Reconfiguration busy flag: power-up offset cancellation and access pulses
`timescale 1ns/1ps
`include "bsrs_defines.svh"
module bsrs_reconf_busy (
   // Clock and synchronised reset
   input logic clk,
   input logic rst_n,
   // Read or write made to the reconfiguration controller
   input logic access,
   // Status
   output logic busy,
   output logic cancel_done
);

   bsrs_pkg::bsrs_oc_state_type state_q;
   logic [`BSRS_CNT_W-1:0] cnt_q;

   // Low for one cycle, then cancellation, then quiet except on access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= bsrs_pkg::OC_FIRST;
         cnt_q <= '0;
      end else begin
         case (state_q)
            bsrs_pkg::OC_FIRST: begin
               state_q <= bsrs_pkg::OC_CANCEL;
               cnt_q <= `BSRS_CNT_W'(`BSRS_OFFSET_CANCEL_CYC - 1);
            end
            bsrs_pkg::OC_CANCEL: begin
               if (cnt_q == '0) begin
                  state_q <= bsrs_pkg::OC_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            bsrs_pkg::OC_IDLE: begin
               if (access) begin
                  state_q <= bsrs_pkg::OC_RECONF;
                  cnt_q <= `BSRS_CNT_W'(`BSRS_RECONF_BUSY_CYC - 1);
               end
            end
            default: begin
               // A further access stretches the pulse rather than queueing
               if (access) begin
                  cnt_q <= `BSRS_CNT_W'(`BSRS_RECONF_BUSY_CYC - 1);
               end else if (cnt_q == '0) begin
                  state_q <= bsrs_pkg::OC_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
         endcase
      end
   end

   // Decoded from the state flops
   assign busy = (state_q == bsrs_pkg::OC_CANCEL) || (state_q == bsrs_pkg::OC_RECONF);
   assign cancel_done = (state_q == bsrs_pkg::OC_IDLE) || (state_q == bsrs_pkg::OC_RECONF);

   first_low_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == bsrs_pkg::OC_FIRST) |-> !busy ##1 busy)
      else $error("busy not low then high after power up");
   cancel_end_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      $fell(busy) |-> $past(cnt_q) == '0)
      else $error("busy fell before cancellation finished");
   quiet_idle_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == bsrs_pkg::OC_IDLE && !access) |=> !busy)
      else $error("busy pulsed without an access");
   access_pulse_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == bsrs_pkg::OC_IDLE && access) |=> busy[*8])
      else $error("access did not raise busy");

endmodule : bsrs_reconf_busy

/* File: bsrs_cdr_lane.sv */
// One receive lane: lock mode decode and clock-data-recovery lock state
`timescale 1ns/1ps
`include "bsrs_defines.svh"
module bsrs_cdr_lane #(
   parameter logic [`BSRS_CNT_W-1:0] SKEW = '0
) (
   // Clock and synchronised reset
   input logic clk,
   input logic rst_n,
   // Lane conditions
   input logic enable,
   input logic analog_reset,
   input logic cancel_busy,
   input logic lock_to_reference,
   input logic lock_to_data,
   // Lane status
   output logic freq_locked,
   output bsrs_pkg::bsrs_lock_mode_type lock_mode
);

   bsrs_pkg::bsrs_cdr_state_type state_q;
   logic [`BSRS_CNT_W-1:0] cnt_q;
   logic run;

   // Lock-to-data wins over lock-to-reference
   always_comb begin
      if (lock_to_data) begin
         lock_mode = bsrs_pkg::LOCK_MAN_DATA;
      end else if (lock_to_reference) begin
         lock_mode = bsrs_pkg::LOCK_MAN_REF;
      end else begin
         lock_mode = bsrs_pkg::LOCK_AUTO;
      end
   end

   assign run = enable && !analog_reset && !cancel_busy;

   // Reference lock first; in automatic mode skew makes lanes reach data lock at different times
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= bsrs_pkg::CDR_HOLD;
         cnt_q <= '0;
      end else if (!run) begin
         state_q <= bsrs_pkg::CDR_HOLD;
         cnt_q <= '0;
      end else begin
         case (state_q)
            bsrs_pkg::CDR_HOLD: begin
               state_q <= bsrs_pkg::CDR_REF;
               cnt_q <= `BSRS_CNT_W'(`BSRS_AUTO_LTD_CYC) + SKEW;
            end
            bsrs_pkg::CDR_REF: begin
               if (lock_mode == bsrs_pkg::LOCK_MAN_DATA) begin
                  state_q <= bsrs_pkg::CDR_DATA;
               end else if (lock_mode == bsrs_pkg::LOCK_AUTO) begin
                  if (cnt_q == '0) begin
                     state_q <= bsrs_pkg::CDR_DATA;
                  end else begin
                     cnt_q <= cnt_q - 1'b1;
                  end
               end
            end
            default: begin
               if (lock_mode == bsrs_pkg::LOCK_MAN_REF) begin
                  state_q <= bsrs_pkg::CDR_REF;
                  cnt_q <= `BSRS_CNT_W'(`BSRS_AUTO_LTD_CYC) + SKEW;
               end
            end
         endcase
      end
   end

   // High only while recovering clock from the data
   assign freq_locked = (state_q == bsrs_pkg::CDR_DATA);

   ltd_lock_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (run && lock_to_data)[*2] |=> freq_locked)
      else $error("manual lock-to-data not reached");
   ltr_unlock_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (lock_to_reference && !lock_to_data) |=> !freq_locked)
      else $error("freq lock high in lock-to-reference");
   auto_lock_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (run && state_q == bsrs_pkg::CDR_REF && lock_mode == bsrs_pkg::LOCK_AUTO
       && cnt_q == '0) |=> freq_locked)
      else $error("automatic lock did not move to data");
   auto_delay_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(run) && lock_mode == bsrs_pkg::LOCK_AUTO) |-> !freq_locked[*8])
      else $error("automatic lock came too early");

endmodule : bsrs_cdr_lane

/* File: bsrs_xcvr_top.sv */
// Bonded transceiver reset and lock behaviour with register access
`timescale 1ns/1ps
`include "bsrs_defines.svh"

// Summary of operation
// - Busy low on the first cycle after power up, high from the second.
// - Busy falls once receiver offset cancellation has finished.
// - After power-up cancellation, busy pulses only on reconfiguration read or write.
// - XAUI always bonds four lanes; other modes bond or not.
// - Lock-to-data wins; lock-to-reference alone is manual; neither means automatic.
// - Basic two- and four-lane modes may bond transmitter-only lanes.
// - In XAUI each lane reports its own frequency lock; all count.
// - After PLL reset release the PLL starts acquiring reference lock.
// - Automatic mode: lane frequency locks rise at different times; wait for all.
// - Manual mode: after interval swap to lock-to-data; all lanes lock to data.
// - PLL lock high while the transmit PLL is locked to its reference.
// - Lane frequency lock high in lock-to-data, low in lock-to-reference.
module bsrs_xcvr_top (
   // Clock and asynchronous reset
   input logic clk,
   input logic rst_n,
   // Register port
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [31:0] reg_rdata,
   // Reset controller side
   input bsrs_pkg::bsrs_ctrl_type ctrl,
   output bsrs_pkg::bsrs_stat_type stat
);

   localparam int PLL_MAX = 120;

   logic rst_meta_q;
   logic rst_sync_q;
   logic [1:0] bond_q;
   logic tx_only_q;
   logic cfg_error_q;
   logic [31:0] reconf_data_q;
   logic [`BSRS_CNT_W-1:0] pll_cnt_q;
   logic pll_locked_q;
   logic tx_ready_q;
   logic rx_ready_q;
   logic [31:0] rdata_q;
   logic [`BSRS_N_LANES-1:0] lane_en;
   logic [`BSRS_N_LANES-1:0] lane_lock;
   logic [`BSRS_N_LANES-1:0][1:0] lane_mode;
   logic all_locked;
   logic busy;
   logic cancel_done;
   logic reconf_access;
   logic cfg_wr;
   logic [1:0] wr_bond;
   logic wr_tx_only;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Register write decode
   assign cfg_wr = reg_wr && (reg_addr == `BSRS_REG_CONFIG);
   assign wr_bond = reg_wdata[`BSRS_CFG_MODE_MSB:`BSRS_CFG_MODE_LSB];
   assign wr_tx_only = reg_wdata[`BSRS_CFG_TXONLY_BIT];
   assign reconf_access = (reg_wr || reg_rd) && (reg_addr == `BSRS_REG_RECONF);

   // Bonding configuration; XAUI with transmitter-only is refused and flagged
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         bond_q <= `BSRS_CFG_MODE_RESET;
         tx_only_q <= 1'b0;
         cfg_error_q <= 1'b0;
      end else if (cfg_wr) begin
         if ((wr_bond == bsrs_pkg::BOND_XAUI) && wr_tx_only) begin
            cfg_error_q <= 1'b1;
         end else begin
            bond_q <= wr_bond;
            tx_only_q <= wr_tx_only;
            cfg_error_q <= 1'b0;
         end
      end
   end

   // Scratch word behind the reconfiguration access register
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         reconf_data_q <= 32'h0;
      end else if (reg_wr && (reg_addr == `BSRS_REG_RECONF)) begin
         reconf_data_q <= reg_wdata;
      end
   end

   // Active lanes follow the bond width; XAUI always uses all four
   always_comb begin
      if (tx_only_q) begin
         lane_en = '0;
      end else if (bond_q == bsrs_pkg::BOND_X1) begin
         lane_en = 4'h1;
      end else if (bond_q == bsrs_pkg::BOND_X2) begin
         lane_en = 4'h3;
      end else begin
         lane_en = `BSRS_ALL_LANES;
      end
   end

   // PLL model: lock is lost under reset and regained after a fixed acquire time
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         pll_cnt_q <= `BSRS_CNT_W'(`BSRS_PLL_LOCK_CYC);
         pll_locked_q <= 1'b0;
      end else if (ctrl.pll_reset) begin
         pll_cnt_q <= `BSRS_CNT_W'(`BSRS_PLL_LOCK_CYC);
         pll_locked_q <= 1'b0;
      end else if (pll_cnt_q != '0) begin
         pll_cnt_q <= pll_cnt_q - 1'b1;
      end else begin
         pll_locked_q <= 1'b1;
      end
   end

   // Offset cancellation and reconfiguration busy
   bsrs_reconf_busy u_busy (
      .clk(clk),
      .rst_n(rst_sync_q),
      .access(reconf_access),
      .busy(busy),
      .cancel_done(cancel_done)
   );

   // One recovery unit per lane, each with its own lock skew
   for (genvar i = 0; i < `BSRS_N_LANES; i++) begin : g_lane
      bsrs_cdr_lane #(
         .SKEW(`BSRS_CNT_W'(i * `BSRS_LANE_SKEW_CYC))
      ) u_lane (
         .clk(clk),
         .rst_n(rst_sync_q),
         .enable(lane_en[i]),
         .analog_reset(ctrl.rx_analog_reset),
         .cancel_busy(!cancel_done),
         .lock_to_reference(ctrl.lock_to_reference[i]),
         .lock_to_data(ctrl.lock_to_data[i]),
         .freq_locked(lane_lock[i]),
         .lock_mode(lane_mode[i])
      );
   end

   // Idle lanes never block the group
   assign all_locked = (lane_en != '0) && (&(lane_lock | ~lane_en));

   // Readiness follows the digital resets and lock status
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         tx_ready_q <= 1'b0;
         rx_ready_q <= 1'b0;
      end else begin
         tx_ready_q <= pll_locked_q && !ctrl.tx_digital_reset;
         rx_ready_q <= all_locked && !ctrl.rx_digital_reset;
      end
   end

   // Read data stands for the one cycle after the strobe only
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= 32'h0;
      end else if (!reg_rd) begin
         rdata_q <= 32'h0;
      end else if (reg_addr == `BSRS_REG_CONFIG) begin
         rdata_q <= {29'h0, tx_only_q, bond_q};
      end else if (reg_addr == `BSRS_REG_STATUS) begin
         rdata_q <= {26'h0, rx_ready_q, tx_ready_q, cfg_error_q, all_locked,
                     pll_locked_q, busy};
      end else if (reg_addr == `BSRS_REG_LOCK) begin
         rdata_q <= {20'h0, lane_mode, lane_lock};
      end else if (reg_addr == `BSRS_REG_RECONF) begin
         rdata_q <= reconf_data_q;
      end else begin
         rdata_q <= 32'h0;
      end
   end

   // Outputs
   assign reg_rdata = rdata_q;
   // One driver for the whole status word, in struct member order
   assign stat = {pll_locked_q, busy, lane_lock, tx_ready_q, rx_ready_q};

   pll_hold_a:
   assert property (@(posedge clk) disable iff (!rst_sync_q)
      ctrl.pll_reset |=> !stat.pll_locked)
      else $error("PLL lock high under PLL reset");
   pll_acquire_a:
   assert property (@(posedge clk) disable iff (!rst_sync_q)
      $fell(ctrl.pll_reset) |-> ##[1:PLL_MAX] (stat.pll_locked || ctrl.pll_reset))
      else $error("PLL failed to lock after reset release");
   xaui_bond_a:
   assert property (@(posedge clk) disable iff (!rst_sync_q)
      (bond_q == bsrs_pkg::BOND_XAUI) |-> (lane_en == `BSRS_ALL_LANES) && !tx_only_q)
      else $error("XAUI not bonded across four lanes");
   tx_only_bond_a:
   assert property (@(posedge clk) disable iff (!rst_sync_q)
      (cfg_wr && wr_tx_only && (wr_bond == bsrs_pkg::BOND_X2
       || wr_bond == bsrs_pkg::BOND_X4)) |=> tx_only_q && lane_en == '0)
      else $error("bonded transmitter-only setting refused");
   rx_all_a:
   assert property (@(posedge clk) disable iff (!rst_sync_q)
      $rose(stat.rx_ready) |-> $past(&(lane_lock | ~lane_en)))
      else $error("receive ready before every lane locked");

   cover_cancel_c: cover property (@(posedge clk) disable iff (!rst_sync_q) $fell(busy));
   cover_tx_c: cover property (@(posedge clk) disable iff (!rst_sync_q) $rose(tx_ready_q));
   cover_lock_c: cover property (@(posedge clk) disable iff (!rst_sync_q) $rose(all_locked));
   cover_rx_c: cover property (@(posedge clk) disable iff (!rst_sync_q) $rose(rx_ready_q));

endmodule : bsrs_xcvr_top

/* File: bsrs_ctrl_model.sv */
// Fabric reset controller model that walks the bonded reset and lock sequence
`timescale 1ns/1ps
`include "bsrs_defines.svh"
module bsrs_ctrl_model #(
   parameter int PLL_RST_CYC = 50,
   parameter int AUTO_LTD_CYC = 60,
   parameter int MAN_RTD_CYC = 40,
   parameter int MAN_LTD_CYC = 30
) (
   // Clock and power-up reset
   input logic clk,
   input logic rst_n,
   // Sequence options
   input logic manual,
   input logic tx_only,
   input logic slow,
   // Transceiver side
   input bsrs_pkg::bsrs_stat_type stat,
   output bsrs_pkg::bsrs_ctrl_type ctrl
);
   logic seen_busy_q;

   // Busy must be seen high first, else its low first cycle would pass for done
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_busy_q <= 1'b0;
      end else if (stat.reconfig_busy === 1'b1) begin
         seen_busy_q <= 1'b1;
      end
   end

   // Slow mode stretches every minimum interval set by a parameter; the two cycles after busy falls are not stretched
   task automatic wait_cyc(input int n);
      repeat (n + (slow ? 20 : 0)) @(posedge clk);
   endtask : wait_cyc

   // Everything held; lock-to-reference only in manual mode
   function automatic bsrs_pkg::bsrs_ctrl_type held();
      bsrs_pkg::bsrs_ctrl_type c;
      c = '1;
      c.lock_to_reference = {`BSRS_N_LANES{manual}};
      c.lock_to_data = '0;
      return c;
   endfunction : held

   // One pass of the sequence from power up
   task automatic run_seq();
      ctrl <= held();
      wait_cyc(PLL_RST_CYC);
      ctrl.pll_reset <= 1'b0;
      while (stat.pll_locked !== 1'b1) @(posedge clk);
      ctrl.tx_digital_reset <= 1'b0;
      if (!tx_only) begin
         while (!(seen_busy_q && stat.reconfig_busy === 1'b0)) @(posedge clk);
         repeat (2) @(posedge clk);
         ctrl.rx_analog_reset <= 1'b0;
         if (manual) begin
            wait_cyc(MAN_RTD_CYC);
            ctrl.lock_to_reference <= '0;
            ctrl.lock_to_data <= '1;
            wait_cyc(MAN_LTD_CYC);
         end else begin
            while (stat.rx_freq_locked !== 4'hF) @(posedge clk);
            wait_cyc(AUTO_LTD_CYC);
         end
         ctrl.rx_digital_reset <= 1'b0;
      end
   endtask : run_seq

   // Any new power-up reset throws the pass away and starts over
   initial begin
      ctrl = {4'hF, 8'h00};
      forever begin
         wait (rst_n === 1'b1);
         fork
            run_seq();
         join_none
         @(negedge rst_n);
         disable fork;
         ctrl <= held();
      end
   end
endmodule : bsrs_ctrl_model

/* File: tb_top.sv */
// Self-checking bench for the bonded transceiver reset and lock model
`timescale 1ns/1ps
`include "bsrs_defines.svh"
module tb_top;
   logic clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic use_model;
   logic manual;
   logic slow;
   bsrs_pkg::bsrs_ctrl_type tb_ctrl;
   bsrs_pkg::bsrs_ctrl_type model_ctrl;
   bsrs_pkg::bsrs_ctrl_type ctrl;
   bsrs_pkg::bsrs_stat_type stat;
   int num_errors;
   int total_checks;
   int n;
   logic [31:0] rd;
   // Rows: lock_to_reference, lock_to_data, lane modes, lane locks
   logic [19:0] lock_rows [6] = '{20'hF0550, 20'h0FAAF, 20'hFFAAF, 20'hF0550, 20'h5011A,
                                  20'h0000F};
   // Rows: CONFIG value, lane locks expected
   logic [7:0] bond_rows [4] = '{8'h01, 8'h13, 8'h2F, 8'h60};

   // Controls come from the model or from the bench
   assign ctrl = use_model ? model_ctrl : tb_ctrl;

   bsrs_xcvr_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl(ctrl), .stat(stat));

   bsrs_ctrl_model model (.clk(clk), .rst_n(rst_n), .manual(manual), .tx_only(1'b0),
      .slow(slow), .stat(stat), .ctrl(model_ctrl));

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : reg_read

   // Counts the cycles of the next busy pulse
   task automatic count_busy(output int cnt);
      cnt = 0;
      for (int k = 0; k < 20 && stat.reconfig_busy !== 1'b1; k++) @(negedge clk);
      while (stat.reconfig_busy === 1'b1 && cnt < 1000) begin
         cnt++;
         @(negedge clk);
      end
   endtask : count_busy

   // Power-up reset, then the offset cancellation busy pulse
   task automatic do_reset();
      int cnt;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      check("busy first cycle", stat.reconfig_busy, 1'b0);
      @(negedge clk);
      check("busy second cycle", stat.reconfig_busy, 1'b1);
      count_busy(cnt);
      check("cancel length", cnt, `BSRS_OFFSET_CANCEL_CYC);
   endtask : do_reset

   // Watchdog sized well above the whole run
   initial begin
      #(20 * 10000);
      num_errors++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      use_model = 1'b1;
      manual = 1'b0;
      slow = 1'b0;
      tb_ctrl = '0;
      do_reset();
      $display("test power_up done");
      // Automatic lock sequence run by the model
      for (n = 0; n < 2000 && stat.rx_freq_locked !== 4'hF; n++) @(negedge clk);
      check("rx ready early", stat.rx_ready, 1'b0);
      check("tx ready", stat.tx_ready, 1'b1);
      for (n = 0; n < 2000 && stat.rx_ready !== 1'b1; n++) @(negedge clk);
      reg_read(`BSRS_REG_STATUS, rd);
      check("status auto", rd, 32'h36);
      $display("test auto_sequence done");
      // Bench takes the controls for the lock table
      @(posedge clk);
      tb_ctrl <= '0;
      use_model <= 1'b0;
      foreach (lock_rows[i]) begin
         @(posedge clk);
         tb_ctrl.lock_to_reference <= lock_rows[i][19:16];
         tb_ctrl.lock_to_data <= lock_rows[i][15:12];
         repeat (100) @(negedge clk);
         check("lane locks", stat.rx_freq_locked, lock_rows[i][3:0]);
         reg_read(`BSRS_REG_LOCK, rd);
         check("lock modes", rd, {20'h0, lock_rows[i][11:0]});
      end
      $display("test lock_modes done");
      // Lanes drop on analog reset and lock one after another
      @(posedge clk);
      tb_ctrl.rx_analog_reset <= 1'b1;
      repeat (3) @(negedge clk);
      check("held lanes", stat.rx_freq_locked, 4'h0);
      @(posedge clk);
      tb_ctrl.rx_analog_reset <= 1'b0;
      for (n = 0; n < 200 && stat.rx_freq_locked === 4'h0; n++) @(negedge clk);
      check("first lane", stat.rx_freq_locked, 4'h1);
      check("rx ready partial", stat.rx_ready, 1'b0);
      for (n = 0; n < 200 && stat.rx_freq_locked === 4'h1; n++) @(negedge clk);
      check("lane skew", n, `BSRS_LANE_SKEW_CYC);
      repeat (100) @(negedge clk);
      $display("test lane_stagger done");
      // PLL reset, lock time and transmit ready
      @(posedge clk);
      tb_ctrl.pll_reset <= 1'b1;
      tb_ctrl.tx_digital_reset <= 1'b1;
      repeat (3) @(negedge clk);
      check("pll in reset", stat.pll_locked, 1'b0);
      @(posedge clk);
      tb_ctrl.pll_reset <= 1'b0;
      for (n = 0; n < 300 && stat.pll_locked !== 1'b1; n++) @(negedge clk);
      check("pll lock time", n >= `BSRS_PLL_LOCK_CYC && n <= `BSRS_PLL_LOCK_CYC + 3, 1'b1);
      check("tx held", stat.tx_ready, 1'b0);
      @(posedge clk);
      tb_ctrl.tx_digital_reset <= 1'b0;
      repeat (2) @(negedge clk);
      check("tx released", stat.tx_ready, 1'b1);
      $display("test pll_lock done");
      // Busy stays quiet, then pulses on reconfiguration accesses only
      n = 0;
      repeat (50) begin
         @(negedge clk);
         if (stat.reconfig_busy !== 1'b0) n++;
      end
      check("busy quiet", n, 0);
      reg_write(`BSRS_REG_RECONF, 32'h0000A5C3);
      count_busy(n);
      check("reconf write busy", n, `BSRS_RECONF_BUSY_CYC);
      check("locks kept", stat.rx_freq_locked, 4'hF);
      reg_read(`BSRS_REG_RECONF, rd);
      check("reconf scratch", rd, 32'h0000A5C3);
      count_busy(n);
      check("reconf read busy", n, `BSRS_RECONF_BUSY_CYC);
      $display("test reconf_busy done");
      // Bonding arrangements and enabled lanes
      foreach (bond_rows[i]) begin
         reg_write(`BSRS_REG_CONFIG, {28'h0, bond_rows[i][7:4]});
         repeat (100) @(negedge clk);
         check("enabled locks", stat.rx_freq_locked, bond_rows[i][3:0]);
         check("rx ready bond", stat.rx_ready, bond_rows[i][3:0] != 4'h0);
         reg_read(`BSRS_REG_CONFIG, rd);
         check("config back", rd, {28'h0, bond_rows[i][7:4]});
      end
      // XAUI without receivers is refused; read-only and unmapped places
      reg_write(`BSRS_REG_CONFIG, 32'h7);
      reg_read(`BSRS_REG_STATUS, rd);
      check("refused flag", rd[3], 1'b1);
      reg_read(`BSRS_REG_CONFIG, rd);
      check("config kept", rd, 32'h6);
      reg_write(`BSRS_REG_STATUS, 32'h0);
      reg_read(`BSRS_REG_STATUS, rd);
      check("status read only", rd[3], 1'b1);
      reg_read(8'h10, rd);
      check("unmapped read", rd, 32'h0);
      reg_write(`BSRS_REG_CONFIG, 32'h2);
      reg_read(`BSRS_REG_STATUS, rd);
      check("flag cleared", rd[3], 1'b0);
      $display("test config done");
      // Second power up, manual lock, slow controller
      @(posedge clk);
      use_model <= 1'b1;
      manual <= 1'b1;
      slow <= 1'b1;
      do_reset();
      reg_read(`BSRS_REG_CONFIG, rd);
      check("config reset", rd, 32'h3);
      for (n = 0; n < 2000 && model_ctrl.rx_analog_reset !== 1'b0; n++) @(negedge clk);
      repeat (10) @(negedge clk);
      check("manual ref locks", stat.rx_freq_locked, 4'h0);
      reg_read(`BSRS_REG_LOCK, rd);
      check("manual ref modes", rd[11:4], 8'h55);
      for (n = 0; n < 2000 && stat.rx_ready !== 1'b1; n++) @(negedge clk);
      reg_read(`BSRS_REG_STATUS, rd);
      check("status manual", rd, 32'h36);
      $display("test manual_restart done");
      stop_test();
   end
endmodule : tb_top
